// [inc/seq_pkg.sv]
// Shared constants and types for the rail enable sequencing block
package seq_pkg;

	// Register offsets on the internal register port
	localparam logic [7:0] ADDR_RAIL5_DLY = 8'h15;
	localparam logic [7:0] ADDR_RAIL6_MASK = 8'h16;
	localparam logic [7:0] ADDR_RAIL6_SRC = 8'h17;
	localparam logic [7:0] ADDR_RAIL6_DLY = 8'h18;

	// Reset values before the one-time-programmable image is loaded
	localparam logic [7:0] REG_RESET_VAL = 8'h00;
	localparam logic [7:0] RDATA_UNMAPPED = 8'h00;

	// Field positions
	localparam int FALL_DLY_LSB = 3;
	localparam int RISE_DLY_LSB = 0;
	localparam int STEP_SEL_BIT = 5;
	localparam int SRC_SEL_LSB = 2;
	localparam int SHARED_MASK_BIT = 1;
	localparam int SWB_MASK_BIT = 0;

	// Enable source codes
	localparam logic [2:0] SRC_CTL_ONE = 3'h0;
	localparam logic [2:0] SRC_CTL_TWO = 3'h1;
	localparam logic [2:0] SRC_CTL_FIVE = 3'h2;
	localparam logic [2:0] SRC_CTL_FOUR = 3'h3;
	localparam logic [2:0] SRC_CTL_THREE = 3'h4;
	localparam logic [2:0] SRC_CTL_THREE_FOUR = 3'h5;
	localparam logic [2:0] SRC_CTL_SIX = 3'h6;
	localparam logic [2:0] SRC_FORCED_ONE = 3'h7;

	// Timebase: 100 MHz clock, delays are whole milliseconds
	localparam int unsigned CLK_PERIOD_PS = 10000;
	localparam int unsigned PS_PER_MS = 1000000000;
	localparam int unsigned CYCLES_PER_MS_DEF = PS_PER_MS / CLK_PERIOD_PS;
	localparam int DLY_CNT_W = 23;

	// Delay table in ms for the three-bit edge delay codes
	localparam int unsigned DLY_MS_0 = 0;
	localparam int unsigned DLY_MS_1 = 2;
	localparam int unsigned DLY_MS_2 = 4;
	localparam int unsigned DLY_MS_3 = 8;
	localparam int unsigned DLY_MS_4 = 16;
	localparam int unsigned DLY_MS_5 = 24;
	localparam int unsigned DLY_MS_6 = 32;
	localparam int unsigned DLY_MS_7 = 64;

	function automatic int unsigned delay_ms(input logic [2:0] code);
		int unsigned ms;
		ms = DLY_MS_0;
		unique case (code)
			3'h0: ms = DLY_MS_0;
			3'h1: ms = DLY_MS_1;
			3'h2: ms = DLY_MS_2;
			3'h3: ms = DLY_MS_3;
			3'h4: ms = DLY_MS_4;
			3'h5: ms = DLY_MS_5;
			3'h6: ms = DLY_MS_6;
			3'h7: ms = DLY_MS_7;
		endcase
		return ms;
	endfunction

	// Power-good flags, ordered to line up with the mask bits
	typedef struct packed {
		logic aux_regulator_three;
		logic aux_regulator_two;
		logic load_switch_a;
		logic rail_five;
		logic rail_four;
		logic rail_three;
		logic rail_two;
		logic rail_one;
		logic shared_switch_regulator_one;
		logic load_switch_b_first;
	} power_good_t;

	// Internal register port behind the serial host interface
	typedef struct packed {
		logic wr;
		logic [7:0] addr;
		logic [7:0] wdata;
	} reg_req_t;

	// Power-up image of the sequencing registers
	typedef struct packed {
		logic [7:0] rail5_enable_edge_delay;
		logic [7:0] rail6_power_good_mask_low;
		logic [7:0] rail6_source_select_and_mask;
		logic [7:0] rail6_enable_edge_delay;
	} otp_image_t;

endpackage

// [hw/edge_delay_unit.sv]
// Programmable rising and falling edge delay for one rail enable
`timescale 1ns/1ps
`default_nettype none

module edge_delay_unit
	import seq_pkg::*;
#(
	parameter int unsigned CYCLES_PER_MS = CYCLES_PER_MS_DEF
)
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Delay codes
	input wire logic [2:0] rise_code_i,
	input wire logic [2:0] fall_code_i,
	// Condition in, delayed enable out
	input wire logic cond_i,
	output logic en_o
);

	logic en_r;
	logic en_nxt;
	logic [DLY_CNT_W-1:0] cnt_r;
	logic [DLY_CNT_W-1:0] cnt_nxt;
	logic [DLY_CNT_W-1:0] target;
	int unsigned target_full;

	// A condition that falls back before expiry restarts the wait
	always_comb begin
		target_full = delay_ms(en_r ? fall_code_i : rise_code_i) * CYCLES_PER_MS;
		target = target_full[DLY_CNT_W-1:0];
		en_nxt = en_r;
		cnt_nxt = '0;
		if (cond_i != en_r) begin
			if (({1'b0, cnt_r} + 24'h1) >= {1'b0, target}) begin
				en_nxt = cond_i;
			end else begin
				cnt_nxt = cnt_r + 23'h1;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			en_r <= 1'b0;
			cnt_r <= '0;
		end else begin
			en_r <= en_nxt;
			cnt_r <= cnt_nxt;
		end
	end

	assign en_o = en_r;

	a_rise_no_delay: assert property (@(posedge clk_i) disable iff (rst_i)
		!en_r && cond_i && rise_code_i == 3'h0 |=> en_r)
		else $error("enable did not rise at once with zero delay");

	a_fall_waits: assert property (@(posedge clk_i) disable iff (rst_i)
		en_r && !cond_i && fall_code_i != 3'h0 && cnt_r == '0 |=> en_r)
		else $error("enable fell without its programmed delay");

	c_delayed_rise: cover property (@(posedge clk_i) disable iff (rst_i)
		!en_r && cond_i && rise_code_i != 3'h0 ##1 cond_i [*2] ##[1:300] en_r);

endmodule

`default_nettype wire

// [hw/rail_enable_sequencer.sv]
// Enable sequencing for rails five and six, with masked power-good gating on rail six only
`timescale 1ns/1ps
`default_nettype none

module rail_enable_sequencer
	import seq_pkg::*;
#(
	parameter int unsigned CYCLES_PER_MS = CYCLES_PER_MS_DEF
)
(
	// Clock and reset
	input wire logic SYS_CLK_I,
	input wire logic RESET_I,
	// Register port from the serial host interface
	input wire reg_req_t REG_REQ_I,
	output logic [7:0] REG_RDATA_O,
	// Power-up register image
	input wire otp_image_t OTP_IMAGE_I,
	// External control input pins, one to six in bits 0 to 5
	input wire logic [5:0] CONTROL_INPUT_I,
	// Power-good flags from the regulators
	input wire power_good_t POWER_GOOD_FLAG_I,
	// Rail five enable condition from its own source and mask logic
	input wire logic RAIL_FIVE_COND_I,
	// Rail controls
	output logic RAIL_FIVE_EN_O,
	output logic RAIL_SIX_EN_O,
	output logic RAIL_SIX_STEP_25MV_O
);

	logic [7:0] rail5_enable_edge_delay_r;
	logic [7:0] rail5_enable_edge_delay_nxt;
	logic [7:0] rail6_power_good_mask_low_r;
	logic [7:0] rail6_power_good_mask_low_nxt;
	logic [7:0] rail6_source_select_and_mask_r;
	logic [7:0] rail6_source_select_and_mask_nxt;
	logic [7:0] rail6_enable_edge_delay_r;
	logic [7:0] rail6_enable_edge_delay_nxt;
	logic load_pend_r;
	logic load_pend_nxt;
	logic [7:0] rdata_r;
	logic [7:0] rdata_nxt;
	logic step_r;
	logic step_nxt;

	logic [5:0] ctl_meta_r;
	logic [5:0] ctl_sync_r;
	power_good_t pg_meta_r;
	power_good_t pg_sync_r;

	logic [2:0] src_sel;
	logic [9:0] pg_mask;
	logic pin_level;
	logic pg_ok;
	logic six_cond;

	// Registers: power-up load first, then host writes
	always_comb begin
		rail5_enable_edge_delay_nxt = rail5_enable_edge_delay_r;
		rail6_power_good_mask_low_nxt = rail6_power_good_mask_low_r;
		rail6_source_select_and_mask_nxt = rail6_source_select_and_mask_r;
		rail6_enable_edge_delay_nxt = rail6_enable_edge_delay_r;
		load_pend_nxt = 1'b0;
		if (load_pend_r) begin
			// A host write in the load cycle is dropped; the image wins
			rail5_enable_edge_delay_nxt = OTP_IMAGE_I.rail5_enable_edge_delay;
			rail6_power_good_mask_low_nxt = OTP_IMAGE_I.rail6_power_good_mask_low;
			rail6_source_select_and_mask_nxt =
				OTP_IMAGE_I.rail6_source_select_and_mask;
			rail6_enable_edge_delay_nxt = OTP_IMAGE_I.rail6_enable_edge_delay;
		end else if (REG_REQ_I.wr) begin
			unique case (REG_REQ_I.addr)
				ADDR_RAIL5_DLY: begin
					rail5_enable_edge_delay_nxt = REG_REQ_I.wdata;
				end
				ADDR_RAIL6_MASK: begin
					rail6_power_good_mask_low_nxt = REG_REQ_I.wdata;
				end
				ADDR_RAIL6_SRC: begin
					rail6_source_select_and_mask_nxt = REG_REQ_I.wdata;
				end
				ADDR_RAIL6_DLY: begin
					rail6_enable_edge_delay_nxt = REG_REQ_I.wdata;
				end
				default: begin
					rail5_enable_edge_delay_nxt = rail5_enable_edge_delay_r;
				end
			endcase
		end
	end

	// Read data and step select are registered so outputs come from flops
	always_comb begin
		unique case (REG_REQ_I.addr)
			ADDR_RAIL5_DLY: rdata_nxt = rail5_enable_edge_delay_r;
			ADDR_RAIL6_MASK: rdata_nxt = rail6_power_good_mask_low_r;
			ADDR_RAIL6_SRC: rdata_nxt = rail6_source_select_and_mask_r;
			ADDR_RAIL6_DLY: rdata_nxt = rail6_enable_edge_delay_r;
			default: rdata_nxt = RDATA_UNMAPPED;
		endcase
		step_nxt = rail6_source_select_and_mask_r[STEP_SEL_BIT];
	end

	always_ff @(posedge SYS_CLK_I) begin
		if (RESET_I) begin
			rail5_enable_edge_delay_r <= REG_RESET_VAL;
			rail6_power_good_mask_low_r <= REG_RESET_VAL;
			rail6_source_select_and_mask_r <= REG_RESET_VAL;
			rail6_enable_edge_delay_r <= REG_RESET_VAL;
			load_pend_r <= 1'b1;
			rdata_r <= RDATA_UNMAPPED;
			step_r <= 1'b0;
		end else begin
			rail5_enable_edge_delay_r <= rail5_enable_edge_delay_nxt;
			rail6_power_good_mask_low_r <= rail6_power_good_mask_low_nxt;
			rail6_source_select_and_mask_r <= rail6_source_select_and_mask_nxt;
			rail6_enable_edge_delay_r <= rail6_enable_edge_delay_nxt;
			load_pend_r <= load_pend_nxt;
			rdata_r <= rdata_nxt;
			step_r <= step_nxt;
		end
	end

	// Pins and analog comparators are asynchronous to the timebase
	always_ff @(posedge SYS_CLK_I) begin
		if (RESET_I) begin
			ctl_meta_r <= 6'h00;
			ctl_sync_r <= 6'h00;
			pg_meta_r <= '0;
			pg_sync_r <= '0;
		end else begin
			ctl_meta_r <= CONTROL_INPUT_I;
			ctl_sync_r <= ctl_meta_r;
			pg_meta_r <= POWER_GOOD_FLAG_I;
			pg_sync_r <= pg_meta_r;
		end
	end

	// Rail six gating condition
	always_comb begin
		src_sel = rail6_source_select_and_mask_r[SRC_SEL_LSB +: 3];
		unique case (src_sel)
			SRC_CTL_ONE: pin_level = ctl_sync_r[0];
			SRC_CTL_TWO: pin_level = ctl_sync_r[1];
			SRC_CTL_FIVE: pin_level = ctl_sync_r[4];
			SRC_CTL_FOUR: pin_level = ctl_sync_r[3];
			SRC_CTL_THREE: pin_level = ctl_sync_r[2];
			SRC_CTL_THREE_FOUR: pin_level = ctl_sync_r[2] & ctl_sync_r[3];
			SRC_CTL_SIX: pin_level = ctl_sync_r[5];
			SRC_FORCED_ONE: pin_level = 1'b1;
		endcase
		// Mask bits line up with the flag struct: 1 drops that flag
		pg_mask = {rail6_power_good_mask_low_r,
			rail6_source_select_and_mask_r[SHARED_MASK_BIT],
			rail6_source_select_and_mask_r[SWB_MASK_BIT]};
		pg_ok = &(pg_sync_r | pg_mask);
		six_cond = pin_level & pg_ok;
	end

	// Rail five
	edge_delay_unit #(
		.CYCLES_PER_MS(CYCLES_PER_MS)
	) u_rail_five_delay (
		.clk_i(SYS_CLK_I),
		.rst_i(RESET_I),
		.rise_code_i(rail5_enable_edge_delay_r[RISE_DLY_LSB +: 3]),
		.fall_code_i(rail5_enable_edge_delay_r[FALL_DLY_LSB +: 3]),
		.cond_i(RAIL_FIVE_COND_I),
		.en_o(RAIL_FIVE_EN_O)
	);

	// Rail six
	edge_delay_unit #(
		.CYCLES_PER_MS(CYCLES_PER_MS)
	) u_rail_six_delay (
		.clk_i(SYS_CLK_I),
		.rst_i(RESET_I),
		.rise_code_i(rail6_enable_edge_delay_r[RISE_DLY_LSB +: 3]),
		.fall_code_i(rail6_enable_edge_delay_r[FALL_DLY_LSB +: 3]),
		.cond_i(six_cond),
		.en_o(RAIL_SIX_EN_O)
	);

	assign REG_RDATA_O = rdata_r;
	assign RAIL_SIX_STEP_25MV_O = step_r;

	default clocking cb @(posedge SYS_CLK_I);
	endclocking
	default disable iff (RESET_I);

	a_mask_aux_regs: assert property (
		(!rail6_power_good_mask_low_r[7] && !pg_sync_r.aux_regulator_three) ||
		(!rail6_power_good_mask_low_r[6] && !pg_sync_r.aux_regulator_two)
		|-> !six_cond)
		else $error("unmasked aux regulator flag did not block rail six");

	a_mask_switch_a: assert property (
		!rail6_power_good_mask_low_r[5] && !pg_sync_r.load_switch_a |-> !six_cond)
		else $error("unmasked load switch A flag did not block rail six");

	a_mask_upper_rails: assert property (
		(!rail6_power_good_mask_low_r[4] && !pg_sync_r.rail_five) ||
		(!rail6_power_good_mask_low_r[3] && !pg_sync_r.rail_four)
		|-> !six_cond)
		else $error("unmasked rail four or five flag did not block rail six");

	a_mask_lower_rails: assert property (
		(!rail6_power_good_mask_low_r[2] && !pg_sync_r.rail_three) ||
		(!rail6_power_good_mask_low_r[1] && !pg_sync_r.rail_two) ||
		(!rail6_power_good_mask_low_r[0] && !pg_sync_r.rail_one)
		|-> !six_cond)
		else $error("unmasked rail one to three flag did not block rail six");

	a_mask_shared_flag: assert property (
		!rail6_source_select_and_mask_r[1] &&
		!pg_sync_r.shared_switch_regulator_one |-> !six_cond)
		else $error("unmasked shared switch flag did not block rail six");

	a_mask_switch_b: assert property (
		!rail6_source_select_and_mask_r[0] && !pg_sync_r.load_switch_b_first
		|-> !six_cond)
		else $error("unmasked load switch B flag did not block rail six");

	a_step_follows_bit: assert property (
		##1 RAIL_SIX_STEP_25MV_O ==
		$past(rail6_source_select_and_mask_r[STEP_SEL_BIT]))
		else $error("step select output does not follow its bit");

	a_source_pin_one: assert property (
		src_sel == SRC_CTL_ONE |-> six_cond == (ctl_sync_r[0] & pg_ok))
		else $error("rail six did not follow control input one");

	a_source_forced_one: assert property (
		src_sel == SRC_FORCED_ONE && pg_ok |-> six_cond)
		else $error("forced source did not enable rail six");

	a_power_up_load: assert property (
		load_pend_r |=> rail6_enable_edge_delay_r ==
		$past(OTP_IMAGE_I.rail6_enable_edge_delay) && !load_pend_r)
		else $error("power-up image not loaded");

	c_forced_source: cover property (src_sel == SRC_FORCED_ONE && six_cond);
	c_six_enabled: cover property ($rose(RAIL_SIX_EN_O));
	c_five_dropped: cover property ($fell(RAIL_FIVE_EN_O));
	c_host_write: cover property (REG_REQ_I.wr && !load_pend_r);

endmodule

`default_nettype wire

// [sim/pin_side_model.sv]
// Far-side model driving the control pins, power-good flags and condition
`timescale 1ns/1ps
`default_nettype none

module pin_side_model
	import seq_pkg::*;
(
	// Clock
	input wire logic clk_i,
	// Levels requested by the bench
	input wire logic [5:0] ctl_lvl_i,
	input wire logic [9:0] pg_lvl_i,
	input wire logic cond_lvl_i,
	// Pins into the device
	output logic [5:0] ctl_o,
	output power_good_t pg_o,
	output logic cond_o
);
	initial begin
		ctl_o = 6'h00;
		pg_o = '1;
		cond_o = 1'b0;
	end

	// Pins move a fixed step after the edge so sampling never races
	always @(posedge clk_i) begin
		ctl_o <= #1 ctl_lvl_i;
		pg_o <= #1 pg_lvl_i;
		cond_o <= #1 cond_lvl_i;
	end
endmodule
`default_nettype wire

// [sim/tb_top.sv]
// Self-checking bench for the rail enable sequencing block
`timescale 1ns/1ps
`default_nettype none

module tb_top
	import seq_pkg::*;
;
	// Short millisecond keeps the 64 ms code to 128 cycles
	localparam int unsigned CPM = 2;
	logic sys_clk = 1'b0;
	logic reset = 1'b1;
	reg_req_t req = '0;
	otp_image_t otp = {8'ha5, 8'h5a, 8'hc3, 8'h3c};
	logic [5:0] ctl_lvl = 6'h00;
	logic [9:0] pg_lvl = '1;
	logic cond_lvl = 1'b0;
	logic [5:0] ctl_pin;
	power_good_t pg_pin;
	logic cond_pin;
	logic [7:0] rdata;
	logic [7:0] rd_o;
	logic en5, en6, step;
	int err_count = 0;
	int cmp_count = 0;
	int unsigned ms_tab [8] = '{0, 2, 4, 8, 16, 24, 32, 64};
	logic [5:0] pats [8] = '{6'h00, 6'h01, 6'h02, 6'h04, 6'h08, 6'h10,
		6'h20, 6'h0c};

	always #5 sys_clk = ~sys_clk;

	pin_side_model u_pin_side_model (.clk_i(sys_clk), .ctl_lvl_i(ctl_lvl),
		.pg_lvl_i(pg_lvl), .cond_lvl_i(cond_lvl), .ctl_o(ctl_pin),
		.pg_o(pg_pin), .cond_o(cond_pin));

	rail_enable_sequencer #(.CYCLES_PER_MS(CPM)) u_rail_enable_sequencer (
		.SYS_CLK_I(sys_clk), .RESET_I(reset), .REG_REQ_I(req),
		.REG_RDATA_O(rd_o), .OTP_IMAGE_I(otp), .CONTROL_INPUT_I(ctl_pin),
		.POWER_GOOD_FLAG_I(pg_pin), .RAIL_FIVE_COND_I(cond_pin),
		.RAIL_FIVE_EN_O(en5), .RAIL_SIX_EN_O(en6),
		.RAIL_SIX_STEP_25MV_O(step));

	task automatic report_and_stop();
		if (err_count == 0 && cmp_count > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	task automatic check(input string what, input logic [7:0] seen,
		input logic [7:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			err_count++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic settle(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		#1;
		req = '{wr: 1'b1, addr: a, wdata: d};
		settle(1);
		req.wr = 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge sys_clk);
		#1;
		req.addr = a;
		settle(1);
		d = rd_o;
	endtask

	// Returns just after the edge at which the pins move
	task automatic apply(input logic [5:0] c, input logic [9:0] g,
		input logic k);
		ctl_lvl = c;
		pg_lvl = g;
		cond_lvl = k;
		settle(1);
	endtask

	function automatic int unsigned max1(input int unsigned n);
		return (n == 0) ? 1 : n;
	endfunction

	task automatic edge_chk(input int sel, input int unsigned lat,
		input logic nv);
		repeat (lat - 1) @(posedge sys_clk);
		#1;
		check("enable before delay", {7'h0, sel ? en6 : en5}, {7'h0, ~nv});
		settle(1);
		check("enable after delay", {7'h0, sel ? en6 : en5}, {7'h0, nv});
	endtask

	function automatic logic src_exp(input int c, input logic [5:0] p);
		case (c)
			0: return p[0];
			1: return p[1];
			2: return p[4];
			3: return p[3];
			4: return p[2];
			5: return p[2] & p[3];
			6: return p[5];
			default: return 1'b1;
		endcase
	endfunction

	task automatic mask_try(input int i, input logic [9:0] m, input logic e);
		wr(ADDR_RAIL6_MASK, m[9:2]);
		wr(ADDR_RAIL6_SRC, {3'b000, SRC_FORCED_ONE, m[1:0]});
		apply(6'h00, ~(10'h1 << i), 1'b0);
		settle(4);
		check("masked enable", {7'h0, en6}, {7'h0, e});
	endtask

	initial begin
		repeat (10000) @(posedge sys_clk);
		err_count++;
		report_and_stop();
	end

	initial begin
		repeat (6) @(posedge sys_clk);
		#1;
		reset = 1'b0;
		settle(2);
		for (int a = 0; a < 4; a++) begin
			rd(ADDR_RAIL5_DLY + 8'(a), rdata);
			check("power-up image", rdata, otp[31 - 8 * a -: 8]);
			wr(ADDR_RAIL5_DLY + 8'(a), ~otp[31 - 8 * a -: 8]);
		end
		wr(8'h19, 8'h77);
		for (int a = 0; a < 4; a++) begin
			rd(ADDR_RAIL5_DLY + 8'(a), rdata);
			check("register readback", rdata, ~otp[31 - 8 * a -: 8]);
		end
		rd(8'h19, rdata);
		check("unmapped read", rdata, RDATA_UNMAPPED);
		wr(ADDR_RAIL6_SRC, 8'h20);
		settle(2);
		check("step select", {7'h0, step}, 8'h01);
		wr(ADDR_RAIL6_SRC, 8'h00);
		settle(2);
		check("step select", {7'h0, step}, 8'h00);
		wr(ADDR_RAIL6_MASK, 8'h00);
		wr(ADDR_RAIL6_DLY, 8'h00);
		for (int c = 0; c < 8; c++) begin
			// Step bit stays clear in every write from here on
			wr(ADDR_RAIL6_SRC, {3'b000, 3'(c), 2'b00});
			for (int p = 0; p < 8; p++) begin
				apply(pats[p], '1, 1'b0);
				settle(3);
				check("source", {7'h0, en6}, {7'h0, src_exp(c, pats[p])});
			end
		end
		for (int i = 0; i < 10; i++) begin
			mask_try(i, 10'h1 << i, 1'b1);
			mask_try(i, ~(10'h1 << i), 1'b0);
		end
		// Different rise and fall codes expose swapped fields
		wr(ADDR_RAIL6_MASK, 8'h00);
		wr(ADDR_RAIL6_SRC, {3'b000, SRC_CTL_ONE, 2'b00});
		apply(6'h00, '1, 1'b0);
		settle(3);
		for (int c = 0; c < 8; c++) begin
			wr(ADDR_RAIL5_DLY, {2'b00, 3'(c), 3'(7 - c)});
			wr(ADDR_RAIL6_DLY, {2'b00, 3'(7 - c), 3'(c)});
			apply(6'h01, '1, 1'b1);
			fork
				edge_chk(0, max1(ms_tab[7 - c] * CPM), 1'b1);
				edge_chk(1, 2 + max1(ms_tab[c] * CPM), 1'b1);
			join
			apply(6'h00, '1, 1'b0);
			fork
				edge_chk(0, max1(ms_tab[c] * CPM), 1'b0);
				edge_chk(1, 2 + max1(ms_tab[7 - c] * CPM), 1'b0);
			join
		end
		// A pulse shorter than the rise delay must be filtered out
		wr(ADDR_RAIL5_DLY, 8'h01);
		apply(6'h00, '1, 1'b1);
		settle(1);
		check("pulse held off", {7'h0, en5}, 8'h00);
		apply(6'h00, '1, 1'b0);
		settle(8);
		check("short pulse", {7'h0, en5}, 8'h00);
		report_and_stop();
	end
endmodule
`default_nettype wire
